/* design/accel_decel_profile_select.sv */
// Acceleration/deceleration profile selector for one positioning axis, APB slave.
// Assumes axis status pins may be asynchronous; commands leave as registered levels/pulses.
// Behaviour
// - Trap/S method: ratio 0 trapezoid, 1 to 100 S-curve
// - Advanced S-curve ignores the ratio setting
// - Fixed-time ramp mode disregards advanced selection
// - Speed limit is max; accel time to limit
// - Ramp times scale down with commanded speed
// - Rapid longer than decel: code 51, flag
// - After that error, rapid stop uses decel time
// - Advanced profile stops on smaller of both times
// - Rapid not above decel: stop in rapid time
// - Ratio over 100: error, run trapezoid
// - Ratio selects used portion of sine curve
// - Stop or skip in S decel regenerates
// - External stop and rapid stop also regenerate
// - Skip during end-point processing regenerates
// - Rapid stop in S decel regenerates
// - Rapid time accepted from 1 to 65535
`timescale 1ns/1ns
`default_nettype none
module accel_decel_profile_select
  import accel_profile_pkg::*;
#(
  parameter logic [15:0] RANGE_ERR_CODE = 16'h0001
) (
  input wire logic pclk, // Bus clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic stop_pin, // External stop input
  input wire logic skip_pin, // Skip signal
  input wire logic axis_decel_pin, // Axis is decelerating
  input wire logic axis_endpoint_pin, // Axis in end-point processing
  input wire logic axis_done_pin, // Axis motion complete
  output logic [1:0] profile_sel, // Active profile
  output logic [7:0] sine_portion, // Portion of sine curve used
  output logic [15:0] accel_ramp_ms, // Scaled acceleration time
  output logic [15:0] stop_ramp_ms, // Scaled stop time in force
  output logic axis_run, // Motion granted
  output logic stop_req, // One-cycle stop request
  output logic rapid_stop_active, // Current stop is rapid
  output logic pattern_regen, // One-cycle pattern regeneration
  output logic program_setting_error_flag, // Setting error seen at start
  output logic irq // Level interrupt
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_CALC = 4'b0010, ST_RUN = 4'b0100, ST_STOP = 4'b1000
  } state_t;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  state_t state_q;
  logic [3:0] cfg_q;
  logic [7:0] ratio_q;
  logic [15:0] acc_q, dec_q, rap_q;
  logic [31:0] lim_q, spd_q;
  profile_t prof_q;
  logic [7:0] portion_q;
  logic stop_rapid_l_q, rap_err_q;
  logic [15:0] acc_l_q, dec_l_q, rap_l_q;
  logic [31:0] lim_l_q, spd_l_q;
  logic [15:0] acc_s_q, dec_s_q, rap_s_q, stop_time_q;
  logic [1:0] idx_q;
  logic div_go_q;
  logic err_q;
  logic [15:0] errinfo_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic stop_req_q, regen_q, rapid_act_q;
  logic [31:0] prdata_q;
  logic [4:0] lvl, lvl_prev_q;

  // One shared divider scales the three times in turn: area traded for about 150 cycles
  ramp_div_if dif();
  ramp_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .dif(dif)
  );
  pin_sync #(.WIDTH(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({axis_done_pin, axis_endpoint_pin, axis_decel_pin, skip_pin, stop_pin}),
    .level_out(lvl)
  );

  // Register map, byte offsets from the package:
  // CFG [0] advanced [1] fixed-time ramp [2] stop pin uses rapid time [3] ignore rapid error
  // RATIO [7:0] percent; ACCEL, DECEL, RAPID [15:0] ms; SPDLIM, SPEED full word
  // CMD write-only: [0] start [1] stop [2] rapid stop [3] clear error flag
  // STATUS [3:0] state [5:4] profile [6] error flag [7] rapid stop active
  // IRQ bits: [0] start [1] setting error [2] regeneration [3] motion done
  // Bus decode
  wire logic wr = psel && penable && pwrite;
  wire logic wr_cfg = wr && hit(paddr, OFF_CFG);
  wire logic wr_ratio = wr && hit(paddr, OFF_RATIO);
  wire logic wr_acc = wr && hit(paddr, OFF_ACCEL);
  wire logic wr_dec = wr && hit(paddr, OFF_DECEL);
  wire logic wr_rap = wr && hit(paddr, OFF_RAPID);
  wire logic wr_lim = wr && hit(paddr, OFF_SPDLIM);
  wire logic wr_spd = wr && hit(paddr, OFF_SPEED);
  wire logic wr_cmd = wr && hit(paddr, OFF_CMD);
  wire logic wr_ien = wr && hit(paddr, OFF_IRQ_EN);
  wire logic wr_iclr = wr && hit(paddr, OFF_IRQ_CLR);
  wire logic cmd_start = wr_cmd && pwdata[CMD_START];
  wire logic cmd_stop = wr_cmd && pwdata[CMD_STOP];
  wire logic cmd_rapid = wr_cmd && pwdata[CMD_RAPID];
  wire logic cmd_clr_err = wr_cmd && pwdata[CMD_CLR_ERR];
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= OFF_IRQ_CLR;
  // Zero wait states: every access ends at its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  wire logic [31:0] status_word = {24'h0, rapid_act_q, err_q, prof_q, state_q};
  // Read data is captured in the setup cycle so the access phase needs no wait
  wire logic [31:0] rd_mux =
    hit(paddr, OFF_CFG) ? {28'h0, cfg_q} :
    hit(paddr, OFF_RATIO) ? {24'h0, ratio_q} :
    hit(paddr, OFF_ACCEL) ? {16'h0, acc_q} :
    hit(paddr, OFF_DECEL) ? {16'h0, dec_q} :
    hit(paddr, OFF_RAPID) ? {16'h0, rap_q} :
    hit(paddr, OFF_SPDLIM) ? lim_q :
    hit(paddr, OFF_SPEED) ? spd_q :
    hit(paddr, OFF_STATUS) ? status_word :
    hit(paddr, OFF_ERRINFO) ? {16'h0, errinfo_q} :
    hit(paddr, OFF_ACC_EFF) ? {16'h0, acc_s_q} :
    hit(paddr, OFF_STOP_EFF) ? {16'h0, stop_time_q} :
    hit(paddr, OFF_IRQ_STAT) ? {28'h0, irq_stat_q} :
    hit(paddr, OFF_IRQ_EN) ? {28'h0, irq_en_q} : 32'h0000_0000;
  assign prdata = prdata_q;

  // Start-time checks on the live settings
  wire logic start = cmd_start && state_q == ST_IDLE;
  wire logic adv_sel = cfg_q[CFG_ADV] && !cfg_q[CFG_FIXED];
  wire logic ratio_bad = ratio_q > RATIO_MAX;
  wire logic rap_gt = rap_q > dec_q;
  wire logic rap_err = rap_gt && !cfg_q[CFG_IGNORE];
  wire logic rap_zero = rap_q == 16'h0000;
  wire logic range_err = !adv_sel && ratio_bad || rap_zero;
  wire logic any_err = rap_err || range_err;
  // Advanced ignores the ratio; zero or bad ratio gives a trapezoid
  wire profile_t prof_d = adv_sel ? PROF_ADV :
    (ratio_q == 8'h00 || ratio_bad) ? PROF_TRAP : PROF_SCURVE;
  wire logic [7:0] portion_d = prof_d == PROF_SCURVE ? ratio_q : 8'h00;

  // Times are per the speed limit; run times shrink by speed over limit
  wire logic lim_zero = lim_l_q == 32'h0000_0000;
  wire logic [31:0] v_eff = spd_l_q < lim_l_q ? spd_l_q : lim_l_q;
  wire logic [15:0] t_sel = idx_q == 2'h0 ? acc_l_q : idx_q == 2'h1 ? dec_l_q : rap_l_q;
  assign dif.start = div_go_q;
  assign dif.num = lim_zero ? 48'(t_sel) : 48'(t_sel) * 48'(v_eff);
  assign dif.den = lim_zero ? 32'h0000_0001 : lim_l_q;
  // Speed is capped at the limit, so saturation only guards against a broken divide
  wire logic [15:0] q16 = dif.quot > 48'h00_0000_FFFF ? 16'hFFFF : dif.quot[15:0];

  // Rapid stop time in force
  wire logic [15:0] rap_min = rap_s_q < dec_s_q ? rap_s_q : dec_s_q;
  wire logic [15:0] rapid_sel = prof_q == PROF_ADV ? rap_min :
    rap_err_q ? dec_s_q : rap_s_q;

  // Events
  wire logic [4:0] rise = lvl & ~lvl_prev_q;
  wire logic ext_stop_rise = rise[0];
  wire logic skip_rise = rise[1];
  wire logic decel_lvl = lvl[2];
  wire logic endpoint_lvl = lvl[3];
  wire logic done_rise = rise[4];
  wire logic moving = state_q == ST_RUN || state_q == ST_STOP;
  wire logic rapid_ev = moving && (cmd_rapid ||
    ext_stop_rise && stop_rapid_l_q);
  wire logic decel_ev = state_q == ST_RUN && (cmd_stop ||
    ext_stop_rise && !stop_rapid_l_q || skip_rise);
  wire logic s_prof = prof_q == PROF_SCURVE;
  // Regeneration only for the ratio S-curve; overrun risk stays with the user
  wire logic regen_d = moving && s_prof && (decel_lvl && (decel_ev || rapid_ev) ||
    skip_rise && endpoint_lvl);
  wire logic err_set = start && any_err;
  wire logic err_clr = cmd_clr_err;
  // A done rise outside motion is a stray pin edge and is not reported
  wire logic irq_done_ev = done_rise && moving;
  wire logic [IRQ_W-1:0] irq_ev = {irq_done_ev, regen_d, err_set, start};
  wire logic [IRQ_W-1:0] irq_clr = wr_iclr ? pwdata[IRQ_W-1:0] : '0;

  assign profile_sel = prof_q;
  assign sine_portion = portion_q;
  assign accel_ramp_ms = acc_s_q;
  assign stop_ramp_ms = stop_time_q;
  assign axis_run = moving;
  assign stop_req = stop_req_q;
  assign rapid_stop_active = rapid_act_q;
  assign pattern_regen = regen_q;
  assign program_setting_error_flag = err_q;
  assign irq = |(irq_stat_q & irq_en_q);

  // Software registers
  // Settings written during motion only take effect at the next start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
      ratio_q <= RATIO_RST;
      acc_q <= TIME_RST;
      dec_q <= TIME_RST;
      rap_q <= TIME_RST;
      lim_q <= SPDLIM_RST;
      spd_q <= SPDLIM_RST;
      irq_en_q <= '0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_cfg) cfg_q <= pwdata[3:0];
      if (wr_ratio) ratio_q <= pwdata[7:0];
      if (wr_acc) acc_q <= pwdata[15:0];
      if (wr_dec) dec_q <= pwdata[15:0];
      if (wr_rap) rap_q <= pwdata[15:0];
      if (wr_lim) lim_q <= pwdata;
      if (wr_spd) spd_q <= pwdata;
      if (wr_ien) irq_en_q <= pwdata[IRQ_W-1:0];
      if (psel && !penable) prdata_q <= rd_mux;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
      errinfo_q <= 16'h0000;
      irq_stat_q <= '0;
      lvl_prev_q <= 5'h00;
    end else begin
      err_q <= err_set || err_q && !err_clr;
      if (err_set) errinfo_q <= rap_err ? ERR_RAPID_GT_DECEL : RANGE_ERR_CODE;
      irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
      lvl_prev_q <= lvl;
    end
  end

  // Settings captured at start stay fixed for the whole motion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prof_q <= PROF_TRAP;
      portion_q <= 8'h00;
      stop_rapid_l_q <= 1'b0;
      rap_err_q <= 1'b0;
      acc_l_q <= TIME_RST;
      dec_l_q <= TIME_RST;
      rap_l_q <= TIME_RST;
      lim_l_q <= SPDLIM_RST;
      spd_l_q <= SPDLIM_RST;
    end else if (start) begin
      prof_q <= prof_d;
      portion_q <= portion_d;
      stop_rapid_l_q <= cfg_q[CFG_STOP_RAPID];
      rap_err_q <= rap_err;
      acc_l_q <= acc_q;
      dec_l_q <= dec_q;
      // A zero rapid time is a range error; the stop falls back to the deceleration time
      rap_l_q <= rap_zero ? dec_q : rap_q;
      lim_l_q <= lim_q;
      spd_l_q <= spd_q;
    end
  end

  // Sequencer: scale three times, then run until the axis reports done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      idx_q <= 2'h0;
      div_go_q <= 1'b0;
      acc_s_q <= 16'h0000;
      dec_s_q <= 16'h0000;
      rap_s_q <= 16'h0000;
      stop_time_q <= 16'h0000;
      stop_req_q <= 1'b0;
      regen_q <= 1'b0;
      rapid_act_q <= 1'b0;
    end else begin
      div_go_q <= 1'b0;
      stop_req_q <= 1'b0;
      regen_q <= regen_d;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_CALC;
            idx_q <= 2'h0;
            div_go_q <= 1'b1;
            rapid_act_q <= 1'b0;
          end
        end
        ST_CALC: begin
          if (dif.done) begin
            case (idx_q)
              2'h0: acc_s_q <= q16;
              2'h1: dec_s_q <= q16;
              default: rap_s_q <= q16;
            endcase
            if (idx_q == 2'h2) begin
              state_q <= ST_RUN;
              stop_time_q <= dec_s_q;
            end else begin
              idx_q <= idx_q + 2'h1;
              div_go_q <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (done_rise) begin
            state_q <= ST_IDLE;
          end else if (rapid_ev) begin
            stop_time_q <= rapid_sel;
            stop_req_q <= 1'b1;
            rapid_act_q <= 1'b1;
            state_q <= ST_STOP;
          end else if (decel_ev) begin
            stop_time_q <= dec_s_q;
            stop_req_q <= 1'b1;
            state_q <= ST_STOP;
          end
        end
        // Once stopping, only a first rapid stop can still change the ramp time
        ST_STOP: begin
          if (done_rise) begin
            state_q <= ST_IDLE;
          end else if (rapid_ev && !rapid_act_q) begin
            stop_time_q <= rapid_sel;
            stop_req_q <= 1'b1;
            rapid_act_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // accel_decel_profile_select
`default_nettype wire

/* design/accel_profile_pkg.sv */
// Constants shared by the profile selector, its divider and the link between them.
// Assumes a 32-bit APB register bus with byte addresses in paddr[7:0].
`default_nettype none
package accel_profile_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_RATIO = 8'h04;
  localparam logic [7:0] OFF_ACCEL = 8'h08;
  localparam logic [7:0] OFF_DECEL = 8'h0C;
  localparam logic [7:0] OFF_RAPID = 8'h10;
  localparam logic [7:0] OFF_SPDLIM = 8'h14;
  localparam logic [7:0] OFF_SPEED = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_ERRINFO = 8'h24;
  localparam logic [7:0] OFF_ACC_EFF = 8'h28;
  localparam logic [7:0] OFF_STOP_EFF = 8'h2C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFF_IRQ_EN = 8'h34;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h38;
  // Field positions
  localparam int CFG_ADV = 0;
  localparam int CFG_FIXED = 1;
  localparam int CFG_STOP_RAPID = 2;
  localparam int CFG_IGNORE = 3;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_RAPID = 2;
  localparam int CMD_CLR_ERR = 3;
  localparam int IRQ_W = 4;
  // Reset values
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [7:0] RATIO_RST = 8'h00;
  localparam logic [15:0] TIME_RST = 16'h03E8;
  localparam logic [31:0] SPDLIM_RST = 32'h0000_2710;
  // Limits and codes
  localparam logic [7:0] RATIO_MAX = 8'h64;
  localparam logic [15:0] ERR_RAPID_GT_DECEL = 16'h0033;
  localparam int DIV_NUM_W = 48;
  localparam int DIV_DEN_W = 32;
  typedef enum logic [1:0] {PROF_TRAP = 2'h0, PROF_SCURVE = 2'h1, PROF_ADV = 2'h2} profile_t;
endpackage
`default_nettype wire

/* design/pin_sync.sv */
// Three-stage pin synchroniser; a level counts once stages two and three agree.
// Pins may come from any clock; output is in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Raw pins
  output logic [WIDTH-1:0] level_out // Filtered levels
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
  assign level_out = lvl_q;
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        lvl_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

/* design/ramp_div_if.sv */
// Request and answer link between the selector and its ramp-time divider.
// One client starts a division and waits for the done pulse.
`timescale 1ns/1ns
`default_nettype none
interface ramp_div_if;
  import accel_profile_pkg::*;
  logic start;
  logic [DIV_NUM_W-1:0] num;
  logic [DIV_DEN_W-1:0] den;
  logic busy;
  logic done;
  logic [DIV_NUM_W-1:0] quot;
  modport client(output start, num, den, input busy, done, quot);
  modport server(input start, num, den, output busy, done, quot);
endinterface
`default_nettype wire

/* design/ramp_divider.sv */
// Restoring divider, one quotient bit per pclk cycle.
// Assumes den is non-zero; the client guards that.
`timescale 1ns/1ns
`default_nettype none
module ramp_divider
  import accel_profile_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  ramp_div_if.server dif // Division request and answer
);
  logic [DIV_DEN_W-1:0] rem_q;
  logic [DIV_NUM_W-1:0] quo_q;
  logic [5:0] cnt_q;
  logic busy_q, done_q;
  wire logic [DIV_DEN_W:0] rem_sh = {rem_q, quo_q[DIV_NUM_W-1]};
  wire logic ge = rem_sh >= {1'b0, dif.den};
  wire logic [DIV_DEN_W:0] diff = rem_sh - {1'b0, dif.den};
  assign dif.busy = busy_q;
  assign dif.done = done_q;
  assign dif.quot = quo_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q <= '0;
      quo_q <= '0;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (dif.start && !busy_q) begin
        rem_q <= '0;
        quo_q <= dif.num;
        cnt_q <= 6'(DIV_NUM_W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= ge ? diff[DIV_DEN_W-1:0] : rem_sh[DIV_DEN_W-1:0];
        quo_q <= {quo_q[DIV_NUM_W-2:0], ge};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule // ramp_divider
`default_nettype wire

/* dv/axis_partner.sv */
// Behavioural axis command path: decelerates toward the end point, then completes on a stop.
// Assumes axis_run and stop_req are pclk-registered; slow stretches the stop time.
`timescale 1ns/1ns
`default_nettype none
module axis_partner (
  input wire logic pclk, // Clock
  input wire logic axis_run, // Motion granted
  input wire logic stop_req, // Stop pulse
  input wire logic slow, // Long stop
  output logic axis_decel_pin, // Decelerating
  output logic axis_endpoint_pin, // End-point phase
  output logic axis_done_pin // Motion complete
);
  initial begin
    axis_decel_pin = 1'b0;
    axis_endpoint_pin = 1'b0;
    axis_done_pin = 1'b0;
    forever begin
      while (axis_run !== 1'b1) @(posedge pclk);
      repeat (10) @(posedge pclk);
      axis_decel_pin <= 1'b1;
      axis_endpoint_pin <= 1'b1;
      while (stop_req !== 1'b1) @(posedge pclk);
      // A slow axis keeps the block in its stop state longer
      repeat (slow ? 80 : 20) @(posedge pclk);
      axis_decel_pin <= 1'b0;
      axis_endpoint_pin <= 1'b0;
      axis_done_pin <= 1'b1;
      while (axis_run !== 1'b0) @(posedge pclk);
      axis_done_pin <= 1'b0;
    end
  end
endmodule // axis_partner
`default_nettype wire

/* dv/profile_checker.sv */
// Concurrent checks on the profile selector top-level ports.
// Assumes the single pclk domain with asynchronous presetn; bound at the foot.
`timescale 1ns/1ns
`default_nettype none
module profile_checker
  import accel_profile_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pslverr, // APB error
  input wire logic [1:0] profile_sel, // Profile
  input wire logic [7:0] sine_portion, // Portion
  input wire logic axis_run, // Motion granted
  input wire logic stop_req, // Stop pulse
  input wire logic rapid_stop_active, // Rapid stop
  input wire logic pattern_regen, // Regen pulse
  input wire logic program_setting_error_flag // Error flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic cmd_wr = psel && penable && pwrite && (paddr == OFF_CMD);
  wire logic bad_addr = (paddr > OFF_IRQ_CLR) || (paddr[1:0] != 2'h0);
  AST_PLAIN_PORTION: assert property (profile_sel != PROF_SCURVE |-> sine_portion == 8'h00)
    else $error("portion set outside S-curve");
  AST_SC_RANGE: assert property (profile_sel == PROF_SCURVE |-> sine_portion inside {[8'h01:RATIO_MAX]})
    else $error("S-curve portion out of range");
  AST_HOLD: assert property (axis_run && $past(axis_run) |-> $stable(profile_sel) && $stable(sine_portion))
    else $error("profile changed during motion");
  AST_REGEN_SC: assert property (pattern_regen |-> profile_sel == PROF_SCURVE && axis_run)
    else $error("regen outside S-curve motion");
  AST_STOP_PULSE: assert property (stop_req |=> !stop_req)
    else $error("stop request longer than one cycle");
  AST_RAPID_CMD: assert property (
    axis_run && !rapid_stop_active && cmd_wr && pwdata[CMD_RAPID]
    |=> stop_req && rapid_stop_active)
    else $error("rapid stop not taken");
  AST_ERR_CLEAR: assert property ($fell(program_setting_error_flag) |-> $past(cmd_wr && pwdata[CMD_CLR_ERR]))
    else $error("error flag dropped without clear");
  AST_SLVERR: assert property (psel && penable && bad_addr |-> pslverr)
    else $error("unmapped access without error");
  COV_STOP: cover property (stop_req);
  COV_REGEN: cover property (pattern_regen);
  COV_ERR: cover property ($rose(program_setting_error_flag));
endmodule // profile_checker
bind accel_decel_profile_select profile_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .profile_sel(profile_sel), .sine_portion(sine_portion), .axis_run(axis_run),
  .stop_req(stop_req), .rapid_stop_active(rapid_stop_active), .pattern_regen(pattern_regen),
  .program_setting_error_flag(program_setting_error_flag));
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench: APB register accesses and one table of moves.
// Assumes zero-wait APB and the partner model on the axis pins.
`timescale 1ns/1ns
`default_nettype none
module tb
  import accel_profile_pkg::*;
;
  localparam logic [15:0] RERR = 16'h0001;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stop_pin = 1'b0;
  logic skip_pin = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv, decel, endp, done, axis_run, stop_req, rapid, regen, err_flag, irq;
  logic [1:0] profile_sel;
  logic [7:0] sine_portion;
  logic [15:0] accel_ramp_ms, stop_ramp_ms;
  int num_errors = 0;
  int cmp_count = 0;
  int regen_cnt = 0;
  int cyc = 0;
  logic [15:0] exp_info = 16'h0000;
  accel_decel_profile_select #(.RANGE_ERR_CODE(RERR)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_pin(stop_pin), .skip_pin(skip_pin),
    .axis_decel_pin(decel), .axis_endpoint_pin(endp), .axis_done_pin(done),
    .profile_sel(profile_sel), .sine_portion(sine_portion), .accel_ramp_ms(accel_ramp_ms),
    .stop_ramp_ms(stop_ramp_ms), .axis_run(axis_run), .stop_req(stop_req),
    .rapid_stop_active(rapid), .pattern_regen(regen), .program_setting_error_flag(err_flag),
    .irq(irq));
  axis_partner u_axis (.pclk(pclk), .axis_run(axis_run), .stop_req(stop_req), .slow(slow),
    .axis_decel_pin(decel), .axis_endpoint_pin(endp), .axis_done_pin(done));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // Regen is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge pclk) begin
    if (regen === 1'b1) regen_cnt <= regen_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Speed is half the limit, so every ramp time halves
  function automatic logic [31:0] scl(input logic [15:0] t);
    return t * 32'h1388 / 32'h2710;
  endfunction
  task automatic move(input logic [3:0] cfg, input logic [7:0] ratio, input logic [15:0] rap,
    input int ev, input profile_t prof, input logic [15:0] stp, input logic [15:0] err);
    int r0;
    apb(1'b1, OFF_CMD, 32'h8);
    apb(1'b1, OFF_CFG, {28'h0, cfg});
    apb(1'b1, OFF_RATIO, {24'h0, ratio});
    apb(1'b1, OFF_RAPID, {16'h0, rap});
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    slow <= ~slow;
    r0 = regen_cnt;
    apb(1'b1, OFF_CMD, 32'h1);
    while (axis_run !== 1'b1) @(posedge pclk);
    chk(profile_sel, prof);
    chk(sine_portion, prof == PROF_SCURVE ? ratio : 8'h00);
    chk(accel_ramp_ms, scl(16'h03E8));
    chk(err_flag, err != 16'h0);
    if (err != 16'h0) exp_info = err;
    rchk(OFF_ERRINFO, {16'h0, exp_info});
    apb(1'b1, OFF_RATIO, 32'h0);
    repeat (30) @(posedge pclk);
    chk(sine_portion, prof == PROF_SCURVE ? ratio : 8'h00);
    if (ev == 0) apb(1'b1, OFF_CMD, 32'h2);
    if (ev == 1) apb(1'b1, OFF_CMD, 32'h4);
    if (ev == 2) stop_pin <= 1'b1;
    if (ev == 3) skip_pin <= 1'b1;
    while (axis_run !== 1'b0) @(posedge pclk);
    stop_pin <= 1'b0;
    skip_pin <= 1'b0;
    @(negedge pclk);
    chk(stop_ramp_ms, scl(stp));
    chk(rapid, ev == 1 || (ev == 2 && cfg[CFG_STOP_RAPID]));
    chk(regen_cnt - r0, prof == PROF_SCURVE);
    chk(irq, 1'b0);
    apb(1'b1, OFF_IRQ_EN, 32'h8);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, OFF_IRQ_CLR, 32'h8);
    @(negedge pclk);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_CFG, 32'h0);
    rchk(OFF_RATIO, 32'h0);
    rchk(OFF_ACCEL, 32'h3E8);
    rchk(OFF_DECEL, 32'h3E8);
    rchk(OFF_RAPID, 32'h3E8);
    rchk(OFF_SPDLIM, 32'h2710);
    rchk(OFF_SPEED, 32'h2710);
    rchk(OFF_IRQ_EN, 32'h0);
    apb(1'b1, OFF_STATUS, 32'hFF);
    rchk(OFF_STATUS, 32'h1);
    rchk(8'h3C, 32'h0);
    chk(slv, 1'b1);
    apb(1'b1, OFF_DECEL, 32'h320);
    apb(1'b1, OFF_SPEED, 32'h1388);
    move(4'h0, 8'h00, 16'h012C, 1, PROF_TRAP, 16'h012C, 16'h0);
    move(4'h0, 8'h32, 16'h012C, 0, PROF_SCURVE, 16'h0320, 16'h0);
    move(4'h0, 8'h65, 16'h012C, 1, PROF_TRAP, 16'h012C, RERR);
    move(4'h1, 8'h32, 16'h012C, 1, PROF_ADV, 16'h012C, 16'h0);
    move(4'h3, 8'h32, 16'h012C, 3, PROF_SCURVE, 16'h0320, 16'h0);
    move(4'h0, 8'h32, 16'h04B0, 1, PROF_SCURVE, 16'h0320, ERR_RAPID_GT_DECEL);
    move(4'h8, 8'h64, 16'h04B0, 1, PROF_SCURVE, 16'h04B0, 16'h0);
    move(4'h9, 8'h00, 16'h04B0, 1, PROF_ADV, 16'h0320, 16'h0);
    move(4'h0, 8'h14, 16'h012C, 2, PROF_SCURVE, 16'h0320, 16'h0);
    move(4'h4, 8'h14, 16'h012C, 2, PROF_SCURVE, 16'h012C, 16'h0);
    move(4'h8, 8'h00, 16'hFFFF, 1, PROF_TRAP, 16'hFFFF, 16'h0);
    move(4'h0, 8'h00, 16'h0000, 1, PROF_TRAP, 16'h0320, RERR);
    end_sim();
  end
endmodule // tb
`default_nettype wire
